// ### core/charge_port_consts.vh
`ifndef CHARGE_PORT_CONSTS_VH
`define CHARGE_PORT_CONSTS_VH

// Clock period in ns
`define CLK_PERIOD_NS       10
// Length of the 1.2 V phase, in us
`define PHASE12_TIME_US     1000
// Cycles for the 1.2 V phase
`define PHASE12_CYCLES      ((`PHASE12_TIME_US * 1000) / `CLK_PERIOD_NS)
// Switching clock lock: edges of a valid external clock before locking
`define SYNC_LOCK_EDGES     4'h4
// Longest gap between external clock edges, in cycles
`define SYNC_GAP_CYCLES     16'h03e8
// Width of the sync gap counter
`define SYNC_GAP_W          16

// Attach states
`define ST_OFF              3'h0
`define ST_STARTUP          3'h1
`define ST_UNATTACHED       3'h2
`define ST_ATTACHED         3'h3

// Charging schemes
`define DCP_DIV3            2'h0
`define DCP_V12             2'h1
`define DCP_SHORT           2'h2

`endif

// ### core/edge_sync.v
`default_nettype none
// Two-stage synchroniser with rising-edge pulse out
module edge_sync (
	// Clock and reset
	input  wire i_clk,
	input  wire i_rstn,
	// Input level
	input  wire i_d,
	// Outputs
	output wire o_q,
	output wire o_rise
);
	reg s1_r;
	reg s2_r;
	reg s3_r;

	always @(posedge i_clk) begin
		if (!i_rstn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= i_d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign o_q    = s2_r;
	assign o_rise = s2_r & ~s3_r;
endmodule
`default_nettype wire

// ### core/charge_port_ctrl.v
// Behaviour
// - Once output node clears undervoltage lockout, sample turn-on input; high starts operation.
// - After start-up, watch both CC pins continuously for a sink.
// - Sink seen on either CC pin closes the port power switch.
// - Cable termination Ra on the other CC pin gets VCONN applied.
// - Only one automatic charging state; state machine picks shorted, Divider 3, 1.2 V.
// - Shorted mode ties D+ to D- through at most 200 ohms.
// - Divider 3 drives 2.7 V on both D+ and D-.
// - 1.2 V scheme shorts and pulls lines to 1.2 V, then shorted mode.
// - Auto-detect machine starts in Divider 3.
// - BC1.2 sink: switch back on without discharge, brief 1.2 V, then shorted.
// - Stay shorted until sink releases data line, then back to Divider 3.
// - Divider 3 compliant sink keeps the machine in Divider 3.
// - Shutdown while turn-on input is below its threshold.
// - Converter off on input overvoltage or output node undervoltage.
// - Active mode needs turn-on input, no undervoltage and a valid CC detection.
// - Active mode keeps forced constant switching even with no sink pull-down.
// - Lock switching to any valid clock on the switching clock input.
// - Orientation: released for CC1 sink, driven low for CC2, released when unattached.
`include "charge_port_consts.vh"
`default_nettype none
module charge_port_ctrl #(
	parameter PHASE12_CYCLES = `PHASE12_CYCLES
) (
	// Clock and reset
	input  wire       I_CLK,
	input  wire       I_RSTN,
	// Supply and enable comparators
	input  wire       i_en_above_thr,
	input  wire       i_undervoltage_lockout,
	input  wire       i_overvoltage_lockout,
	// CC comparators
	input  wire       i_cc1_rd,
	input  wire       i_cc2_rd,
	input  wire       i_cc1_ra,
	input  wire       i_cc2_ra,
	// Data line comparator: sink pulls D+ or D- as BC1.2 detection
	input  wire       i_dline_sink_drive,
	// Divider 3 sink seen (2.7 V held by sink)
	input  wire       i_div3_sink,
	// External switching clock
	input  wire       i_switching_clock_input,
	// Converter and power path
	output reg        o_converter_on,
	output reg        o_forced_constant_switching,
	output reg        o_sync_locked,
	output reg        o_port_switch_on,
	output reg        o_port_discharge,
	output reg        o_vconn_cc1,
	output reg        o_vconn_cc2,
	// Orientation open-drain pin
	output reg        o_orientation_flag_out,
	output reg        o_orientation_flag_oe,
	// Data line switches, charge mode and active flag
	output reg        o_dline_short,
	output reg        o_dline_div3,
	output reg        o_dline_pull12,
	output reg  [1:0] o_charge_mode,
	output reg        o_active
);
	localparam [31:0] PH_LAST = PHASE12_CYCLES - 1;

	wire dl_q;
	wire dl_rise;
	wire sc_rise;

	// Data line and external clock synchronised; sink timing is not ours
	edge_sync u_dline (
		.i_clk  (I_CLK),
		.i_rstn (I_RSTN),
		.i_d    (i_dline_sink_drive),
		.o_q    (dl_q),
		.o_rise (dl_rise)
	);

	edge_sync u_sclk (
		.i_clk  (I_CLK),
		.i_rstn (I_RSTN),
		.i_d    (i_switching_clock_input),
		.o_q    (),
		.o_rise (sc_rise)
	);

	reg  [2:0]  att_r;
	reg  [2:0]  att_nxt;
	reg  [1:0]  dcp_r;
	reg  [1:0]  dcp_nxt;
	reg  [31:0] ph_cnt_r;
	reg  [15:0] gap_r;
	reg  [3:0]  edges_r;
	reg         sink_cc2_r;

	wire undervoltage_lockout_ok   = ~i_undervoltage_lockout;
	wire supply_ok = undervoltage_lockout_ok & ~i_overvoltage_lockout;
	// Debug-accessory Rd/Rd also counts; only orientation differs
	wire sink_seen = i_cc1_rd | i_cc2_rd;
	wire attached  = (att_r == `ST_ATTACHED);

	// Attach sequencing
	always @* begin
		att_nxt = att_r;
		case (att_r)
			`ST_OFF: begin
				if (undervoltage_lockout_ok)
					att_nxt = `ST_STARTUP;
			end
			`ST_STARTUP: begin
				if (!undervoltage_lockout_ok)
					att_nxt = `ST_OFF;
				else if (i_en_above_thr)
					att_nxt = `ST_UNATTACHED;
			end
			`ST_UNATTACHED: begin
				if (!undervoltage_lockout_ok || !i_en_above_thr)
					att_nxt = `ST_OFF;
				else if (sink_seen)
					att_nxt = `ST_ATTACHED;
			end
			`ST_ATTACHED: begin
				if (!undervoltage_lockout_ok || !i_en_above_thr)
					att_nxt = `ST_OFF;
				else if (!sink_seen)
					att_nxt = `ST_UNATTACHED;
			end
			default: att_nxt = `ST_OFF;
		endcase
	end

	// Charging scheme selection
	always @* begin
		dcp_nxt = dcp_r;
		if (!attached) begin
			dcp_nxt = `DCP_DIV3;
		end else begin
			case (dcp_r)
				`DCP_DIV3: begin
					// Divider 3 sink holds 2.7 V; no data line drive seen
					if (dl_rise && !i_div3_sink)
						dcp_nxt = `DCP_V12;
					else
						dcp_nxt = `DCP_DIV3;
				end
				`DCP_V12: begin
					if (ph_cnt_r >= PH_LAST)
						dcp_nxt = `DCP_SHORT;
				end
				`DCP_SHORT: begin
					if (!dl_q)
						dcp_nxt = `DCP_DIV3;
				end
				default: dcp_nxt = `DCP_DIV3;
			endcase
		end
	end

	// Attach state register
	always @(posedge I_CLK) begin
		if (!I_RSTN) begin
			att_r <= `ST_OFF;
		end else begin
			att_r <= att_nxt;
		end
	end

	// Charging scheme register
	always @(posedge I_CLK) begin
		if (!I_RSTN) begin
			dcp_r <= `DCP_DIV3;
		end else begin
			dcp_r <= dcp_nxt;
		end
	end

	// Cleared outside the phase so every entry gets the full time
	always @(posedge I_CLK) begin
		if (!I_RSTN) begin
			ph_cnt_r <= 32'h0000_0000;
		end else if (dcp_r == `DCP_V12) begin
			ph_cnt_r <= ph_cnt_r + 32'h0000_0001;
		end else begin
			ph_cnt_r <= 32'h0000_0000;
		end
	end

	// Orientation latched at attach so a later Ra does not flip it
	always @(posedge I_CLK) begin
		if (!I_RSTN) begin
			sink_cc2_r <= 1'b0;
		end else if (att_r == `ST_UNATTACHED && sink_seen) begin
			sink_cc2_r <= i_cc2_rd & ~i_cc1_rd;
		end
	end

	reg  [15:0] gap_nxt;
	reg  [3:0]  edges_nxt;

	// Lock needs several edges each within the gap limit; a lost clock drops it
	always @* begin
		gap_nxt   = gap_r;
		edges_nxt = edges_r;
		if (sc_rise) begin
			gap_nxt = 16'h0000;
			if (edges_r != `SYNC_LOCK_EDGES)
				edges_nxt = edges_r + 4'h1;
		end else if (gap_r >= `SYNC_GAP_CYCLES) begin
			edges_nxt = 4'h0;
		end else begin
			gap_nxt = gap_r + 16'h0001;
		end
	end

	always @(posedge I_CLK) begin
		if (!I_RSTN) begin
			gap_r   <= 16'h0000;
			edges_r <= 4'h0;
		end else begin
			gap_r   <= gap_nxt;
			edges_r <= edges_nxt;
		end
	end

	// Converter group
	always @(posedge I_CLK) begin
		if (!I_RSTN) begin
			o_converter_on              <= 1'b0;
			o_forced_constant_switching <= 1'b0;
			o_sync_locked               <= 1'b0;
			o_active                    <= 1'b0;
		end else begin
			// Converter runs once enabled, regardless of sink presence
			o_converter_on <= supply_ok & i_en_above_thr
				& (att_r == `ST_UNATTACHED || attached);
			o_forced_constant_switching <= supply_ok & i_en_above_thr;
			o_sync_locked <= (edges_r == `SYNC_LOCK_EDGES) & supply_ok;
			// Converter off in lockout, so active cannot outlive it
			o_active <= i_en_above_thr & supply_ok & attached & sink_seen;
		end
	end

	// Port power path
	always @(posedge I_CLK) begin
		if (!I_RSTN) begin
			o_port_switch_on <= 1'b0;
			o_port_discharge <= 1'b0;
			o_vconn_cc1      <= 1'b0;
			o_vconn_cc2      <= 1'b0;
		end else begin
			o_port_switch_on <= attached & sink_seen & ~i_overvoltage_lockout;
			// Scheme changes never discharge the output
			o_port_discharge <= ~attached & (att_r != `ST_OFF);
			// Ra only on the pin opposite the sink
			o_vconn_cc1 <= attached & i_cc1_ra & i_cc2_rd & ~i_cc1_rd;
			o_vconn_cc2 <= attached & i_cc2_ra & i_cc1_rd & ~i_cc2_rd;
		end
	end

	// Orientation pin; released the cycle the sink goes
	always @(posedge I_CLK) begin
		if (!I_RSTN) begin
			o_orientation_flag_out <= 1'b0;
			o_orientation_flag_oe  <= 1'b0;
		end else begin
			o_orientation_flag_out <= 1'b0;
			o_orientation_flag_oe  <= attached & sink_seen & sink_cc2_r;
		end
	end

	// Data line switches
	always @(posedge I_CLK) begin
		if (!I_RSTN) begin
			o_charge_mode  <= `DCP_DIV3;
			o_dline_div3   <= 1'b0;
			o_dline_pull12 <= 1'b0;
			o_dline_short  <= 1'b0;
		end else begin
			o_charge_mode  <= dcp_r;
			o_dline_div3   <= attached & (dcp_r == `DCP_DIV3);
			o_dline_pull12 <= attached & (dcp_r == `DCP_V12);
			o_dline_short  <= attached
				& (dcp_r == `DCP_V12 || dcp_r == `DCP_SHORT);
		end
	end
endmodule
`default_nettype wire

// ### test/charge_port_ctrl_properties.sv
`include "charge_port_consts.vh"
`default_nettype none
module charge_port_checker #(
	parameter PHASE12_CYCLES = 20
) (
	// Clock, reset, comparators
	input wire logic       I_CLK, I_RSTN, i_en_above_thr, i_undervoltage_lockout,
	input wire logic       i_overvoltage_lockout, i_cc1_rd, i_cc2_rd, i_cc2_ra,
	// Outputs, plus the data line comparator
	input wire logic       o_converter_on, o_forced_constant_switching, o_port_switch_on,
	input wire logic       o_vconn_cc1, o_vconn_cc2, o_orientation_flag_oe, o_port_discharge,
	input wire logic       i_dline_sink_drive,
	input wire logic       o_dline_short, o_dline_div3, o_dline_pull12, o_active,
	input wire logic [1:0] o_charge_mode
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);
	switch_cause_a: assert property ($rose(o_port_switch_on) |-> $past(i_cc1_rd | i_cc2_rd))
		else $error("switch closed without sink");
	lockout_off_a: assert property (i_overvoltage_lockout | i_undervoltage_lockout
		|-> ##1 !o_converter_on) else $error("converter on in lockout");
	enable_low_a: assert property (!i_en_above_thr |-> ##1 !o_converter_on && !o_active)
		else $error("not shut down");
	vconn_pin_a: assert property (o_vconn_cc2 |-> $past(i_cc2_ra) && !o_vconn_cc1)
		else $error("vconn without cable");
	div3_lines_a: assert property (o_active && o_charge_mode == `DCP_DIV3
		|-> o_dline_div3 && !o_dline_short) else $error("div3 lines wrong");
	pull12_lines_a: assert property ($rose(o_dline_pull12) |-> o_dline_short
		&& !o_port_discharge && o_charge_mode == `DCP_V12) else $error("v12 entry wrong");
	short_exit_a: assert property (o_charge_mode == `DCP_SHORT && !i_dline_sink_drive
		|-> ##[1:5] o_charge_mode == `DCP_DIV3) else $error("short mode stuck");
	orient_idle_a: assert property (!$past(i_cc1_rd | i_cc2_rd) |-> !o_orientation_flag_oe)
		else $error("orientation driven unattached");
	active_fcs_a: assert property (o_active |-> o_converter_on && o_forced_constant_switching)
		else $error("active without forced switching");
endmodule
bind charge_port_ctrl charge_port_checker #(.PHASE12_CYCLES(PHASE12_CYCLES)) chk (.*);
`default_nettype wire

// ### test/usb_sink_model.sv
`default_nettype none
module usb_sink_model (
	// Sink presence and behaviour
	input  wire logic attach, flip, cable, drive, d3,
	// Comparator view at the receptacle
	output logic      i_cc1_rd, i_cc2_rd, i_cc1_ra, i_cc2_ra, i_dline_sink_drive, i_div3_sink
);
	timeunit 1ns;
	timeprecision 1ps;
	// Rd reaches only the pin mated to the plug
	assign i_cc1_rd = attach & ~flip;
	assign i_cc2_rd = attach & flip;
	assign i_cc1_ra = attach & cable & flip;
	assign i_cc2_ra = attach & cable & ~flip;
	// Lines released the moment the sink leaves
	assign i_dline_sink_drive = attach & drive;
	assign i_div3_sink = attach & d3;
endmodule
`default_nettype wire

// ### test/usb_charge_port_mode_control_test.sv
`include "charge_port_consts.vh"
`default_nettype none
module usb_charge_port_mode_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PH = 20;
	logic I_CLK = 0, I_RSTN = 0, i_en_above_thr = 0, i_overvoltage_lockout = 0;
	logic i_undervoltage_lockout = 1, i_switching_clock_input = 0;
	logic attach = 0, flip = 0, cable = 0, drive = 0, d3 = 0;
	wire logic i_cc1_rd, i_cc2_rd, i_cc1_ra, i_cc2_ra, i_dline_sink_drive, i_div3_sink;
	logic o_converter_on, o_forced_constant_switching, o_sync_locked, o_port_switch_on;
	logic o_port_discharge, o_vconn_cc1, o_vconn_cc2, o_orientation_flag_out, o_active;
	logic o_orientation_flag_oe, o_dline_short, o_dline_div3, o_dline_pull12;
	logic [1:0] o_charge_mode;
	int errors = 0, total_checks = 0, i;
	always #5 I_CLK = ~I_CLK;
	charge_port_ctrl #(.PHASE12_CYCLES(PH)) uut (.*);
	usb_sink_model sink (.*);
	task automatic chk(input string name, input logic [1:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge I_CLK);
	endtask
	// VCONN goes to the pin opposite the sink
	function automatic logic [1:0] vconn_exp(input logic c, f);
		return {c & f, c & ~f};
	endfunction
	task automatic final_report();
		$display("Checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		void'($urandom(15747));
		cyc(20);
		I_RSTN = 1;
		cyc(3);
		chk("conv", 0, o_converter_on);
		i_undervoltage_lockout = 0;
		cyc(4);
		chk("conv", 0, o_converter_on);
		i_en_above_thr = 1;
		cyc(4);
		chk("fcs", 1, o_forced_constant_switching & o_converter_on);
		chk("act", 0, o_active);
		for (i = 0; i < 8; i++) begin
			{flip, cable} = (i < 4) ? 2'(i) : 2'($urandom_range(3));
			attach = 1;
			cyc(4);
			chk("switch", 1, o_port_switch_on & o_active);
			chk("vconn", vconn_exp(cable, flip), {o_vconn_cc1, o_vconn_cc2});
			chk("orient", {1'b0, flip}, {o_orientation_flag_out, o_orientation_flag_oe});
			chk("mode", `DCP_DIV3, o_charge_mode);
			chk("div3", 1, o_dline_div3);
			drive = 1;
			d3 = i[0];
			cyc(6);
			if (d3) begin
				cyc(PH);
				chk("mode", `DCP_DIV3, o_charge_mode);
			end else begin
				chk("mode", `DCP_V12, o_charge_mode);
				chk("v12", 2'h3, {o_dline_pull12, o_dline_short});
				chk("disch", 0, o_port_discharge);
				cyc(PH + 2);
				chk("mode", `DCP_SHORT, o_charge_mode);
				chk("short", 2'h1, {o_dline_pull12, o_dline_short});
			end
			drive = 0;
			cyc(6);
			chk("mode", `DCP_DIV3, o_charge_mode);
			attach = 0;
			cyc(4);
			chk("detach", 0, o_port_switch_on | o_orientation_flag_oe);
			chk("disch", 1, o_port_discharge);
		end
		repeat (12) begin
			i_switching_clock_input = ~i_switching_clock_input;
			cyc(20);
		end
		chk("sync", 1, o_sync_locked);
		cyc(1100);
		chk("sync", 0, o_sync_locked);
		attach = 1;
		i_overvoltage_lockout = 1;
		cyc(4);
		chk("conv", 0, o_converter_on);
		i_overvoltage_lockout = 0;
		cyc(4);
		i_en_above_thr = 0;
		cyc(3);
		chk("act", 0, o_active | o_converter_on);
		final_report();
	end
endmodule
`default_nettype wire
